// >>> fasl_pkg.sv
// package of constants for the flash access status and lock block
package fasl_pkg;
	localparam logic [11:0] FASL_ACCESS_STATUS_OFS = 12'h000;
	localparam logic [11:0] FASL_IRQ_ENABLE_OFS = 12'h004;
	localparam logic [11:0] FASL_CMD_OFS = 12'h008;
	localparam logic [11:0] FASL_CODE_RANGE_OFS = 12'h00C;
	localparam logic [11:0] FASL_DATA_RANGE_OFS = 12'h010;
	localparam int FASL_CODE_BIT = 7;
	localparam int FASL_LOCK_BIT = 4;
	localparam int FASL_DATA_BIT = 3;
	localparam int FASL_CRCT_BIT = 0;
	localparam int FASL_CODE_AW = 24;
	localparam int FASL_DATA_AW = 19;
	localparam logic [7:0] FASL_STATUS_RESET = 8'h00;
	localparam logic [7:0] FASL_STATUS_MASK = 8'h99;
	localparam logic [7:0] FASL_IRQ_ENABLE_RESET = 8'h99;
	localparam logic [23:0] FASL_CODE_LIMIT_RESET = 24'hFFFFFF;
	localparam logic [18:0] FASL_DATA_LIMIT_RESET = 19'h7FFFF;
	// command codes written to the command register
	typedef enum logic [1:0] {
		FASL_CMD_NONE = 2'b00,
		FASL_CMD_CLEAR = 2'b01,
		FASL_CMD_STOP = 2'b10,
		FASL_CMD_RUN = 2'b11
	} fasl_cmd_type;
	localparam int FASL_MODE_CODE = 0;
	localparam int FASL_MODE_DATA = 1;
endpackage

// >>> fasl_status_lock.sv
// access status, command lock and apb register file
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ps
module fasl_status_lock
	import fasl_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cmd_issue,
	input wire logic [1:0] cmd_kind,
	input wire logic code_pe_mode,
	input wire logic data_pe_mode,
	input wire logic [23:0] start_address,
	input wire logic single_bit_corrected,
	input wire logic correction_source,
	output logic command_locked,
	output logic illegal_error_flag,
	output logic access_error_interrupt,
	output logic cmd_accept
);
	// status flags and the read-one latches behind the clear-by-zero rule
	logic code_violation_flag;
	logic data_violation_flag;
	logic lock_flag;
	logic correction_flag;
	logic code_seen;
	logic data_seen;
	logic [7:0] access_error_irq_enable;
	logic [23:0] code_limit;
	logic [18:0] data_limit;
	logic next_code_violation_flag;
	logic next_data_violation_flag;
	logic next_lock_flag;
	logic next_correction_flag;
	logic next_code_seen;
	logic next_data_seen;
	logic [7:0] next_access_error_irq_enable;
	logic [23:0] next_code_limit;
	logic [18:0] next_data_limit;
	logic [31:0] next_prdata;
	logic next_illegal_error_flag;
	logic next_cmd_accept;
	logic next_irq;

	logic wr_acc;
	logic rd_acc;
	logic bus_cmd;
	logic [1:0] bus_cmd_kind;
	logic [1:0] eff_kind;
	logic eff_issue;
	logic clear_start;
	logic code_bad;
	logic data_bad;
	logic [7:0] status_view;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
		return a == o;
	endfunction

	// bus access phase; slave answers with no wait state
	assign wr_acc = psel & penable & pwrite;
	assign rd_acc = psel & penable & ~pwrite;
	assign bus_cmd = wr_acc & hit(paddr, FASL_CMD_OFS);
	assign bus_cmd_kind = pwdata[1:0];
	assign eff_issue = cmd_issue | bus_cmd;
	assign eff_kind = bus_cmd ? bus_cmd_kind : cmd_kind;
	assign clear_start = eff_issue & ((eff_kind == FASL_CMD_CLEAR) |
		(eff_kind == FASL_CMD_STOP));
	// range checks only on a run command in its mode
	assign code_bad = eff_issue & (eff_kind == FASL_CMD_RUN) &
		code_pe_mode & (start_address > code_limit);
	assign data_bad = eff_issue & (eff_kind == FASL_CMD_RUN) &
		data_pe_mode & (start_address[18:0] > data_limit);

	// reserved bits always read as their reset value
	assign status_view = {code_violation_flag, 2'b00, lock_flag,
		data_violation_flag, 2'b00, correction_flag};

	// next state of the status flags
	always_comb begin
		next_code_violation_flag = code_violation_flag;
		next_data_violation_flag = data_violation_flag;
		next_lock_flag = lock_flag;
		next_correction_flag = correction_flag;
		next_code_seen = code_seen;
		next_data_seen = data_seen;
		// remember a read that returned one
		if (rd_acc && hit(paddr, FASL_ACCESS_STATUS_OFS)) begin
			next_code_seen = code_violation_flag;
			next_data_seen = data_violation_flag;
		end
		// write zero clears only after that read
		if (wr_acc && hit(paddr, FASL_ACCESS_STATUS_OFS)) begin
			if (!pwdata[FASL_CODE_BIT] && code_seen)
				next_code_violation_flag = 1'b0;
			if (!pwdata[FASL_DATA_BIT] && data_seen)
				next_data_violation_flag = 1'b0;
			next_code_seen = 1'b0;
			next_data_seen = 1'b0;
		end
		// lock release on a clear or stop start once both violations are gone
		if (clear_start && !code_violation_flag && !data_violation_flag)
			next_lock_flag = 1'b0;
		// correction flag cleared by clear or stop start when correction_source is set
		if (clear_start && correction_source)
			next_correction_flag = 1'b0;
		if (single_bit_corrected)
			next_correction_flag = 1'b1;
		// code or data violation set, winning over a clear
		if (code_bad && !lock_flag)
			next_code_violation_flag = 1'b1;
		if (data_bad && !lock_flag)
			next_data_violation_flag = 1'b1;
		if ((code_bad || data_bad) && !lock_flag)
			next_lock_flag = 1'b1;
		// a stale violation keeps the lock standing
		if (next_code_violation_flag || next_data_violation_flag)
			next_lock_flag = 1'b1;
	end

	// all flags come out of reset cleared
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			code_violation_flag <= 1'b0;
			data_violation_flag <= 1'b0;
			lock_flag <= 1'b0;
			correction_flag <= 1'b0;
			code_seen <= 1'b0;
			data_seen <= 1'b0;
		end else begin
			code_violation_flag <= next_code_violation_flag;
			data_violation_flag <= next_data_violation_flag;
			lock_flag <= next_lock_flag;
			correction_flag <= next_correction_flag;
			code_seen <= next_code_seen;
			data_seen <= next_data_seen;
		end
	end

	// configuration registers written by software
	always_comb begin
		next_access_error_irq_enable = access_error_irq_enable;
		next_code_limit = code_limit;
		next_data_limit = data_limit;
		if (wr_acc && hit(paddr, FASL_IRQ_ENABLE_OFS))
			next_access_error_irq_enable = pwdata[7:0] & FASL_STATUS_MASK;
		if (wr_acc && hit(paddr, FASL_CODE_RANGE_OFS))
			next_code_limit = pwdata[23:0];
		if (wr_acc && hit(paddr, FASL_DATA_RANGE_OFS))
			next_data_limit = pwdata[18:0];
	end

	// enable register resets to all four flag enables
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			access_error_irq_enable <= FASL_IRQ_ENABLE_RESET;
			code_limit <= FASL_CODE_LIMIT_RESET;
			data_limit <= FASL_DATA_LIMIT_RESET;
		end else begin
			access_error_irq_enable <= next_access_error_irq_enable;
			code_limit <= next_code_limit;
			data_limit <= next_data_limit;
		end
	end

	// read mux and registered outputs
	always_comb begin
		next_prdata = 32'h00000000;
		if (psel && !penable && !pwrite) begin
			unique case (paddr)
			FASL_ACCESS_STATUS_OFS: next_prdata = {24'h000000, status_view};
			FASL_IRQ_ENABLE_OFS:
				next_prdata = {24'h000000, access_error_irq_enable};
			FASL_CODE_RANGE_OFS: next_prdata = {8'h00, code_limit};
			FASL_DATA_RANGE_OFS: next_prdata = {13'h0000, data_limit};
			default: next_prdata = 32'h00000000;
			endcase
		end
		// illegal error follows any violation flag
		next_illegal_error_flag = next_code_violation_flag |
			next_data_violation_flag;
		// only an unlocked sequencer accepts a run command
		next_cmd_accept = eff_issue & (eff_kind == FASL_CMD_RUN) &
			~lock_flag & ~code_bad & ~data_bad;
		// enabled flags drive the interrupt line
		next_irq = |({next_code_violation_flag, 2'b00, next_lock_flag,
			next_data_violation_flag, 2'b00, next_correction_flag} &
			access_error_irq_enable);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			command_locked <= 1'b0;
			illegal_error_flag <= 1'b0;
			access_error_interrupt <= 1'b0;
			cmd_accept <= 1'b0;
		end else begin
			prdata <= next_prdata;
			pready <= psel & ~penable;
			pslverr <= 1'b0;
			command_locked <= next_lock_flag;
			illegal_error_flag <= next_illegal_error_flag;
			access_error_interrupt <= next_irq;
			cmd_accept <= next_cmd_accept;
		end
	end

	// checks beside the logic; a lock is two steps, cause then flag
	sequence s_violation;
		code_bad && !lock_flag;
	endsequence
	sequence s_locked_after;
		##1 lock_flag && code_violation_flag;
	endsequence
	sequence s_data_violation;
		data_bad && !lock_flag;
	endsequence
	sequence s_data_locked_after;
		##1 lock_flag && data_violation_flag;
	endsequence

	AST_CODE_SETS_LOCK: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_violation |-> s_locked_after)
		else $error("code violation did not lock");
	AST_DATA_SETS: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_data_violation |=> data_violation_flag)
		else $error("data violation not set");
	AST_DATA_SETS_LOCK: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_data_violation |-> s_data_locked_after)
		else $error("data violation did not lock");

	AST_LOCK_HOLDS: assert property (
		@(posedge pclk) disable iff (!presetn)
		(code_violation_flag || data_violation_flag) |-> lock_flag)
		else $error("violation without lock");
	AST_LOCKED_REFUSES: assert property (
		@(posedge pclk) disable iff (!presetn)
		lock_flag |=> !cmd_accept)
		else $error("run accepted while locked");
	AST_ILLEGAL: assert property (
		@(posedge pclk) disable iff (!presetn)
		illegal_error_flag == (code_violation_flag || data_violation_flag))
		else $error("illegal error missing");

	AST_NO_BLIND_CLEAR: assert property (
		@(posedge pclk) disable iff (!presetn)
		(code_violation_flag && !code_seen && !code_bad) |=>
		code_violation_flag)
		else $error("flag cleared without read");
	AST_LOCK_OUT: assert property (
		@(posedge pclk) disable iff (!presetn)
		command_locked == lock_flag)
		else $error("lock output lags");
	AST_LOCK_KEEPS: assert property (
		@(posedge pclk) disable iff (!presetn)
		(lock_flag && !clear_start) |=> lock_flag)
		else $error("lock dropped without clear");
	AST_UNLOCK: assert property (
		@(posedge pclk) disable iff (!presetn)
		(clear_start && !code_violation_flag && !data_violation_flag &&
		!code_bad && !data_bad) |=> !lock_flag)
		else $error("lock not released");

	AST_CRCT_SET: assert property (
		@(posedge pclk) disable iff (!presetn)
		single_bit_corrected |=> correction_flag)
		else $error("correction not flagged");
	AST_CRCT_CLR: assert property (
		@(posedge pclk) disable iff (!presetn)
		(clear_start && correction_source && !single_bit_corrected) |=>
		!correction_flag)
		else $error("correction not cleared");
	AST_RESERVED: assert property (
		@(posedge pclk) disable iff (!presetn)
		(pready && paddr == FASL_ACCESS_STATUS_OFS) |->
		(prdata[7:0] & ~FASL_STATUS_MASK) == 8'h00)
		else $error("reserved bit set");
	AST_IRQ_GATE: assert property (
		@(posedge pclk) disable iff (!presetn)
		(access_error_irq_enable == 8'h00) |=> !access_error_interrupt)
		else $error("masked interrupt fired");
endmodule // fasl_status_lock

// >>> fasl_host_model.sv
// processor side model: apb master and command sequences
`timescale 1ns/1ps
module fasl_host_model (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
	end
	// one apb cycle; held until pready, then a gap edge
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d; // stale bus data must not look valid
		@(posedge pclk);
	endtask
	// read, write zero, then clear command
	task automatic unlock();
		logic [31:0] r;
		xfer(1'b0, 12'h000, 32'h0, r);
		xfer(1'b1, 12'h000, 32'h0, r); // reserved bits back as zero
		xfer(1'b1, 12'h008, 32'h1, r);
	endtask
endmodule // fasl_host_model

// >>> fasl_status_lock_test.sv
// self-checking bench of the access status and lock block
`timescale 1ns/1ps
module fasl_status_lock_test;
	import fasl_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic cmd_issue, code_pe_mode, data_pe_mode, single_bit_corrected;
	logic correction_source, command_locked, illegal_error_flag;
	logic access_error_interrupt, cmd_accept;
	logic [1:0] cmd_kind;
	logic [23:0] start_address;
	int n_errors = 0, n_checks = 0, cyc = 0, n_accept = 0, a0 = 0;
	typedef struct {logic code; logic [23:0] a; logic [7:0] exp;} fasl_row_type;
	fasl_row_type rows [4] = '{'{1, 24'h100000, 8'h90},
		'{1, 24'h0FFFFF, 8'h00}, '{0, 24'h010000, 8'h18},
		'{0, 24'h00FFFF, 8'h00}};
	fasl_status_lock DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cmd_issue(cmd_issue), .cmd_kind(cmd_kind),
		.code_pe_mode(code_pe_mode), .data_pe_mode(data_pe_mode),
		.start_address(start_address),
		.single_bit_corrected(single_bit_corrected),
		.correction_source(correction_source),
		.command_locked(command_locked),
		.illegal_error_flag(illegal_error_flag),
		.access_error_interrupt(access_error_interrupt),
		.cmd_accept(cmd_accept));
	fasl_host_model host (.pclk(pclk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready));
	// clock at 5 ns period
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	task automatic chk(string name, logic [31:0] exp, logic [31:0] seen);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// one-cycle command pulse, flags set on the edge that samples it, then two more edges
	task automatic cmd(logic [1:0] k, logic code, logic [23:0] a);
		cmd_issue <= 1'b1;
		cmd_kind <= k;
		code_pe_mode <= code;
		data_pe_mode <= ~code;
		start_address <= a;
		@(posedge pclk);
		cmd_issue <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask
	// hang guard, far above the roughly 160 cycles used
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			wrap_up();
		end
	end
	// accepted runs, counted on the edge after the one-cycle pulse
	always @(posedge pclk) begin
		if (cmd_accept === 1'b1) n_accept++;
	end
	initial begin
		presetn = 1'b0;
		{cmd_issue, code_pe_mode, data_pe_mode} = 3'b000;
		{single_bit_corrected, correction_source} = 2'b00;
		cmd_kind = 2'b00;
		start_address = 24'h0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		host.xfer(1'b0, 12'h000, 32'h0, r);
		chk("status after reset", 32'h0, r);
		chk("lock after reset", 1'b0, command_locked);
		host.xfer(1'b0, 12'h004, 32'h0, r);
		chk("enable reset", 32'h99, r);
		host.xfer(1'b0, 12'h0FC, 32'h0, r);
		chk("unmapped read", 32'h0, r);
		$display("reset test done");
		host.xfer(1'b1, 12'h00C, 32'h000FFFFF, r);
		host.xfer(1'b1, 12'h010, 32'h0000FFFF, r);
		for (int i = 0; i < 4; i++) begin
			a0 = n_accept;
			cmd(2'b11, rows[i].code, rows[i].a);
			chk("accept", rows[i].exp == 0, n_accept - a0);
			host.xfer(1'b1, 12'h000, 32'h0, r);
			host.xfer(1'b0, 12'h000, 32'h0, r);
			chk("status", {24'h0, rows[i].exp}, r);
			chk("lock", rows[i].exp != 0, command_locked);
			chk("illegal", rows[i].exp != 0, illegal_error_flag);
			chk("irq", rows[i].exp != 0, access_error_interrupt);
			host.unlock();
			repeat (2) @(posedge pclk);
			host.xfer(1'b0, 12'h000, 32'h0, r);
			chk("status cleared", 32'h0, r);
			chk("unlocked", 32'h0, command_locked);
			$display("row %0d done", i);
		end
		// locked sequencer refuses a data violation command
		a0 = n_accept;
		cmd(2'b11, 1'b1, 24'hFFFFFF);
		cmd(2'b11, 1'b0, 24'h07FFFF);
		chk("refused", 32'h0, n_accept - a0);
		host.xfer(1'b0, 12'h000, 32'h0, r);
		chk("locked refuse", 32'h90, r);
		host.unlock();
		$display("lock test done");
		// correction flag, clear ignored without a source flag
		single_bit_corrected <= 1'b1;
		@(posedge pclk);
		single_bit_corrected <= 1'b0;
		repeat (2) @(posedge pclk);
		cmd(2'b01, 1'b1, 24'h0);
		host.xfer(1'b0, 12'h000, 32'h0, r);
		chk("correction kept", 32'h01, r);
		chk("no lock", 1'b0, command_locked);
		correction_source <= 1'b1;
		cmd(2'b10, 1'b1, 24'h0);
		host.xfer(1'b0, 12'h000, 32'h0, r);
		chk("correction clear", 32'h0, r);
		$display("correction test done");
		// reset in mid-run must drop a standing lock
		cmd(2'b11, 1'b1, 24'hFFFFFF);
		chk("lock before reset", 1'b1, command_locked);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("lock after mid reset", 1'b0, command_locked);
		chk("illegal after reset", 1'b0, illegal_error_flag);
		host.xfer(1'b0, 12'h000, 32'h0, r);
		chk("status after mid reset", 32'h0, r);
		$display("mid-run reset test done");
		wrap_up();
	end
endmodule // fasl_status_lock_test
